// ### logic/sata_tf_pkg.sv
package sata_tf_pkg;
  // bus geometry: word index is byte address bits 11:2
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int MAX_PORTS = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // task file command block, word indices
  localparam logic [9:0] IDX_FEATURES = 10'h1f1;
  localparam logic [9:0] IDX_LBA_HIGH = 10'h1f5;
  localparam logic [9:0] IDX_DEVICE = 10'h1f6;
  localparam logic [9:0] IDX_CMD_STATUS = 10'h1f7;
  localparam int TF_FIFO_REGS = 5;
  // control block, word indices
  localparam logic [9:0] IDX_DEVCTL_SEC = 10'h376;
  localparam logic [9:0] IDX_DEVCTL_PRI = 10'h3f6;
  // block control and status, word indices
  localparam logic [9:0] IDX_MODE = 10'h100;
  localparam logic [9:0] IDX_CAPS = 10'h101;
  localparam logic [9:0] IDX_PORTS = 10'h102;
  localparam logic [9:0] IDX_PORT_EN = 10'h103;
  localparam logic [9:0] IDX_INT_STAT = 10'h104;
  localparam logic [9:0] IDX_INT_CLR = 10'h105;
  localparam logic [9:0] IDX_INT_EN = 10'h106;
  localparam logic [9:0] IDX_FIS0 = 10'h108;
  localparam logic [9:0] IDX_FIS4 = 10'h10c;
  // field positions
  localparam int DC_HOB = 7;
  localparam int DC_SRST = 2;
  localparam int DC_NIEN = 1;
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int MD_AHCI = 0;
  localparam int MD_LEGACY = 1;
  localparam int MD_AUTOACT = 2;
  localparam int CAP_NCQ = 0;
  localparam int CAP_AUTOACT = 1;
  localparam int CAP_SIGREC = 2;
  localparam int CAP_ASYNC = 3;
  localparam int CAP_LINKPM = 4;
  localparam int CAP_STAGGER = 5;
  localparam int CAP_ESATA = 6;
  localparam int CAP_LEGACY = 7;
  localparam int CAP_RATE = 8;
  localparam int PR_EN = 0;
  localparam int PR_PRESENT = 4;
  localparam int PR_LINK = 8;
  localparam int PR_SWITCH = 16;
  localparam int INT_W = 3;
  localparam int INT_CMD = 0;
  localparam int INT_LOCK = 1;
  localparam int INT_LOS = 2;
  // codes
  localparam logic [1:0] RATE_3G = 2'h2;
  localparam logic [1:0] RATE_6G = 2'h3;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] FIS_H2D = 8'h27;
  localparam logic [7:0] FIS_CMD_FLAG = 8'h80;
  localparam logic [7:0] DEVICE_RST = 8'h00;
  localparam logic [7:0] DEVCTL_RST = 8'h00;
  // link recovery idle time after a loss of signal
  localparam int CLK_MHZ = 40;
  localparam int RECOVER_NS = 1000;
  localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int RCNT_W = 8;

  typedef struct packed {
    logic [7:0] earlier;
    logic [7:0] latest;
  } tf_pair_t;

  // byte 0 sits in the low bits
  typedef struct packed {
    logic [31:0] rsvd4;
    logic [7:0] control;
    logic [7:0] icc;
    logic [7:0] count_exp;
    logic [7:0] count;
    logic [7:0] features_exp;
    logic [7:0] lba5;
    logic [7:0] lba4;
    logic [7:0] lba3;
    logic [7:0] device;
    logic [7:0] lba2;
    logic [7:0] lba1;
    logic [7:0] lba0;
    logic [7:0] features;
    logic [7:0] command;
    logic [7:0] flags;
    logic [7:0] fis_type;
  } h2d_fis_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_WAIT_SLAVE = 3'b100
  } cmd_state_t;
endpackage

// ### logic/sata_legacy_taskfile_emulation.sv
`timescale 1ns/10ps
// Overview of operation
// - interlock pin low means switch closed, high means open
// - open-drain activity led pulled low during command activity, else released
// - four-port build has lanes 3:0, two-port build only lanes 1:0
// - two-port build reports 6 Gb/s, four-port build 3 Gb/s
// - with auto-activate on, a dma setup also starts the dma transfer
// - links recover after loss of signal and come up on hot-plug
// - two-port build never offers external cabled operation
// - legacy ide mode exists only in the two-port build
// - ahci off drops queuing, auto-activate, recovery, notify, pm, external
// - shadow command and control registers emulate an ide adapter
// - diagnostic: interrupt on master done, busy held until slave done
// - diagnostic: slave done first means busy already clear at master done
// - task file writes land in their own byte of the h2d fis
// - each task file register from features to lba high keeps its two latest writes
// - control bit 7 clear reads latest write, set reads earlier write
// - activity led asserted whenever busy is set
module sata_legacy_taskfile_emulation
  import sata_tf_pkg::*;
#(
  parameter int NUM_PORTS = 4, // 4 or 2 port build
  parameter int RECOVER_CYCLES = RECOVER_CYC // idle before relink
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic interlock_switch_input, // 0 closed, 1 open
  output logic activity_led_low_out, // led pin level
  output logic activity_led_low_oe, // led pin driven
  output logic host_interrupt_line, // legacy interrupt
  output logic irq, // enabled status interrupt
  output logic [NUM_PORTS-1:0] port_tx_positive, // tx lane p
  output logic [NUM_PORTS-1:0] port_tx_negative, // tx lane n
  input wire logic [NUM_PORTS-1:0] port_rx_positive, // rx lane p
  input wire logic [NUM_PORTS-1:0] port_rx_negative, // rx lane n
  input wire logic master_done, // master drive done pulse
  input wire logic slave_done, // slave drive done pulse
  input wire logic dma_setup_rx, // dma setup seen pulse
  input wire logic dma_activate_rx, // dma activate seen pulse
  output logic dma_go, // start dma transfer pulse
  output h2d_fis_t fis_out, // assembled command fis
  output logic fis_send // fis ready pulse
);

  // build-dependent features
  localparam logic TWO_PORT = (NUM_PORTS == 2);
  localparam logic [1:0] RATE_CODE = TWO_PORT ? RATE_6G : RATE_3G;
  localparam logic [RCNT_W-1:0] RCNT_LOAD = RCNT_W'(RECOVER_CYCLES);

  // bus slave state
  logic aw_hold, next_aw_hold;
  logic w_hold, next_w_hold;
  logic [IDX_W-1:0] aw_idx, next_aw_idx;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_wr, do_rd;
  logic [IDX_W-1:0] ar_idx;

  // task file and control state
  tf_pair_t tf [TF_FIFO_REGS];
  tf_pair_t next_tf [TF_FIFO_REGS];
  logic [7:0] device_reg, next_device_reg;
  logic [7:0] devctl, next_devctl;
  cmd_state_t state, next_state;
  logic is_diag, next_is_diag;
  logic slave_seen, next_slave_seen;
  logic host_interrupt_line_pend, next_host_interrupt_line_pend;
  logic ahci_on, next_ahci_on;
  logic legacy_on, next_legacy_on;
  logic autoact, next_autoact;
  logic [NUM_PORTS-1:0] port_en, next_port_en;
  logic [INT_W-1:0] int_stat, next_int_stat;
  logic [INT_W-1:0] int_en, next_int_en;
  logic [INT_W-1:0] int_clr, int_ev;
  logic lock_q, next_lock_q;
  h2d_fis_t next_fis;
  logic next_fis_send, next_dma_go;
  logic next_host_int, next_irq, next_led_oe;
  logic busy, auto_act_on;
  logic [31:0] caps;
  logic [159:0] fis_bits;
  logic [2:0] tf_k;
  logic [7:0] tf_rd;

  // per-port link status
  logic [NUM_PORTS-1:0] port_los;
  logic [NUM_PORTS-1:0] port_present;
  logic [NUM_PORTS-1:0] port_link;

  function automatic logic mapped(input logic [IDX_W-1:0] i);
    mapped = (i >= IDX_FEATURES && i <= IDX_CMD_STATUS) ||
             (i >= IDX_MODE && i <= IDX_INT_EN) ||
             (i >= IDX_FIS0 && i <= IDX_FIS4) ||
             i == IDX_DEVCTL_PRI || i == IDX_DEVCTL_SEC;
  endfunction

  // capability word follows mode and build
  always_comb begin
    caps = 32'h0000_0000;
    caps[CAP_NCQ] = ahci_on;
    caps[CAP_AUTOACT] = ahci_on;
    caps[CAP_SIGREC] = ahci_on;
    caps[CAP_ASYNC] = ahci_on;
    caps[CAP_LINKPM] = ahci_on;
    caps[CAP_STAGGER] = 1'b1;
    caps[CAP_ESATA] = ahci_on & ~TWO_PORT;
    caps[CAP_LEGACY] = TWO_PORT;
    caps[CAP_RATE +: 2] = RATE_CODE;
  end

  assign busy = (state != ST_IDLE);
  assign auto_act_on = ahci_on & autoact;
  assign do_wr = aw_hold & w_hold & ~bvalid;
  assign do_rd = arvalid & arready;
  assign ar_idx = araddr[ADDR_W-1:2];
  assign fis_bits = fis_out;

  // read-side fifo slot select by control bit 7
  always_comb begin
    tf_k = 3'(ar_idx - IDX_FEATURES);
    tf_rd = 8'h00;
    if (ar_idx >= IDX_FEATURES && ar_idx <= IDX_LBA_HIGH) begin
      tf_rd = devctl[DC_HOB] ? tf[tf_k].earlier : tf[tf_k].latest;
    end
  end

  // next-state logic for bus, task file, command and interrupts
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_idx = aw_idx;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_tf = tf;
    next_device_reg = device_reg;
    next_devctl = devctl;
    next_state = state;
    next_is_diag = is_diag;
    next_slave_seen = slave_seen;
    next_host_interrupt_line_pend = host_interrupt_line_pend;
    next_ahci_on = ahci_on;
    next_legacy_on = legacy_on;
    next_autoact = autoact;
    next_port_en = port_en;
    next_int_en = int_en;
    next_fis = fis_out;
    next_fis_send = 1'b0;
    int_clr = '0;
    int_ev = '0;

    // address and data channels taken in either order
    if (awvalid && awready) begin
      next_aw_hold = 1'b1;
      next_aw_idx = awaddr[ADDR_W-1:2];
    end
    if (wvalid && wready) begin
      next_w_hold = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end

    // command completion sequencing
    case (state)
      ST_IDLE: begin
      end
      ST_BUSY: begin
        if (slave_done) begin
          next_slave_seen = 1'b1;
        end
        if (master_done) begin
          next_host_interrupt_line_pend = 1'b1;
          int_ev[INT_CMD] = 1'b1;
          if (is_diag && !(slave_seen || slave_done)) begin
            next_state = ST_WAIT_SLAVE;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_WAIT_SLAVE: begin
        if (slave_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // register writes
    if (do_wr) begin
      next_bvalid = 1'b1;
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bresp = mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      if (w_lane) begin
        if (aw_idx >= IDX_FEATURES && aw_idx <= IDX_LBA_HIGH) begin
          for (int k = 0; k < TF_FIFO_REGS; k++) begin
            if (aw_idx == IDX_FEATURES + IDX_W'(k)) begin
              next_tf[k].earlier = tf[k].latest;
              next_tf[k].latest = w_byte;
            end
          end
        end
        case (aw_idx)
          IDX_DEVICE: begin
            next_device_reg = w_byte;
          end
          IDX_CMD_STATUS: begin
            if (!busy) begin
              next_state = ST_BUSY;
              next_is_diag = (w_byte == CMD_DIAG);
              next_slave_seen = 1'b0;
              next_fis_send = 1'b1;
              next_fis.fis_type = FIS_H2D;
              next_fis.flags = FIS_CMD_FLAG;
              next_fis.command = w_byte;
              next_fis.features = tf[0].latest;
              next_fis.features_exp = tf[0].earlier;
              next_fis.count = tf[1].latest;
              next_fis.count_exp = tf[1].earlier;
              next_fis.lba0 = tf[2].latest;
              next_fis.lba3 = tf[2].earlier;
              next_fis.lba1 = tf[3].latest;
              next_fis.lba4 = tf[3].earlier;
              next_fis.lba2 = tf[4].latest;
              next_fis.lba5 = tf[4].earlier;
              next_fis.device = device_reg;
              next_fis.control = devctl;
              next_fis.icc = 8'h00;
              next_fis.rsvd4 = 32'h0000_0000;
            end
          end
          IDX_DEVCTL_PRI, IDX_DEVCTL_SEC: begin
            next_devctl = w_byte;
            if (w_byte[DC_SRST]) begin
              next_state = ST_IDLE;
              next_host_interrupt_line_pend = 1'b0;
            end
          end
          IDX_MODE: begin
            next_ahci_on = w_byte[MD_AHCI];
            next_legacy_on = w_byte[MD_LEGACY] & TWO_PORT;
            next_autoact = w_byte[MD_AUTOACT];
          end
          IDX_PORT_EN: begin
            next_port_en = w_byte[NUM_PORTS-1:0];
          end
          IDX_INT_CLR: begin
            int_clr = w_byte[INT_W-1:0];
          end
          IDX_INT_EN: begin
            next_int_en = w_byte[INT_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end

    // register reads
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (do_rd) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      if (ar_idx >= IDX_FEATURES && ar_idx <= IDX_LBA_HIGH) begin
        next_rdata[7:0] = tf_rd;
      end
      if (ar_idx >= IDX_FIS0 && ar_idx <= IDX_FIS4) begin
        next_rdata = fis_bits[32 * 3'(ar_idx - IDX_FIS0) +: 32];
      end
      case (ar_idx)
        IDX_DEVICE: begin
          next_rdata[7:0] = device_reg;
        end
        IDX_CMD_STATUS: begin
          next_rdata[ST_BSY] = busy;
          next_rdata[ST_DRDY] = ~busy;
          next_host_interrupt_line_pend = 1'b0; // status read acknowledges
        end
        IDX_MODE: begin
          next_rdata[MD_AHCI] = ahci_on;
          next_rdata[MD_LEGACY] = legacy_on;
          next_rdata[MD_AUTOACT] = autoact;
        end
        IDX_CAPS: begin
          next_rdata = caps;
        end
        IDX_PORTS: begin
          next_rdata[PR_EN +: NUM_PORTS] = port_en;
          next_rdata[PR_PRESENT +: NUM_PORTS] = port_present;
          next_rdata[PR_LINK +: NUM_PORTS] = port_link;
          next_rdata[PR_SWITCH] = ~lock_q;
        end
        IDX_PORT_EN: begin
          next_rdata[NUM_PORTS-1:0] = port_en;
        end
        IDX_INT_STAT: begin
          next_rdata[INT_W-1:0] = int_stat;
        end
        IDX_INT_EN: begin
          next_rdata[INT_W-1:0] = int_en;
        end
        default: begin
        end
      endcase
    end
    // completion arriving with a status read still counts
    if (state == ST_BUSY && master_done) begin
      next_host_interrupt_line_pend = 1'b1;
    end

    // outputs registered from next values
    next_awready = ~next_aw_hold & ~next_bvalid;
    next_wready = ~next_w_hold & ~next_bvalid;
    next_arready = ~next_rvalid;
    int_ev[INT_LOCK] = (interlock_switch_input != lock_q);
    int_ev[INT_LOS] = |port_los;
    next_lock_q = interlock_switch_input;
    next_int_stat = (int_stat & ~int_clr) | int_ev;
    next_irq = |(next_int_stat & next_int_en);
    next_host_int = next_host_interrupt_line_pend & ~next_devctl[DC_NIEN];
    next_led_oe = (next_state != ST_IDLE);
    next_dma_go = dma_activate_rx | (dma_setup_rx & auto_act_on);
  end

  // core registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_idx <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      for (int k = 0; k < TF_FIFO_REGS; k++) begin
        tf[k] <= '0;
      end
      device_reg <= DEVICE_RST;
      devctl <= DEVCTL_RST;
      state <= ST_IDLE;
      is_diag <= 1'b0;
      slave_seen <= 1'b0;
      host_interrupt_line_pend <= 1'b0;
      ahci_on <= 1'b0;
      legacy_on <= 1'b0;
      autoact <= 1'b0;
      port_en <= '0;
      int_stat <= '0;
      int_en <= '0;
      lock_q <= 1'b1;
      fis_out <= '0;
      fis_send <= 1'b0;
      dma_go <= 1'b0;
      host_interrupt_line <= 1'b0;
      irq <= 1'b0;
      activity_led_low_oe <= 1'b0;
      activity_led_low_out <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_idx <= next_aw_idx;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      tf <= next_tf;
      device_reg <= next_device_reg;
      devctl <= next_devctl;
      state <= next_state;
      is_diag <= next_is_diag;
      slave_seen <= next_slave_seen;
      host_interrupt_line_pend <= next_host_interrupt_line_pend;
      ahci_on <= next_ahci_on;
      legacy_on <= next_legacy_on;
      autoact <= next_autoact;
      port_en <= next_port_en;
      int_stat <= next_int_stat;
      int_en <= next_int_en;
      lock_q <= next_lock_q;
      fis_out <= next_fis;
      fis_send <= next_fis_send;
      dma_go <= next_dma_go;
      host_interrupt_line <= next_host_int;
      irq <= next_irq;
      activity_led_low_oe <= next_led_oe;
      activity_led_low_out <= 1'b0; // open drain only pulls low
    end
  end

  // per-port link bring-up, loss detect and recovery
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic present, next_present;
    logic link, next_link;
    logic dead, next_dead;
    logic los;
    logic [RCNT_W-1:0] rcnt, next_rcnt;
    logic txp, next_txp;
    logic next_txn;

    // rx pair differing means a signal is present
    always_comb begin
      next_present = port_rx_positive[p] ^ port_rx_negative[p];
      next_link = link;
      next_dead = dead;
      next_rcnt = rcnt;
      los = 1'b0;
      if (!port_en[p]) begin
        next_link = 1'b0;
        next_dead = 1'b0;
        next_rcnt = '0;
      end else if (rcnt != '0) begin
        next_rcnt = rcnt - 1'b1;
      end else if (present && !next_present) begin
        los = 1'b1;
        next_link = 1'b0;
        if (ahci_on) begin
          next_rcnt = RCNT_LOAD;
        end else begin
          next_dead = 1'b1;
        end
      end else if (next_present && !dead) begin
        next_link = 1'b1;
      end
      next_txp = (port_en[p] && next_rcnt == '0) ? ~txp : 1'b0;
      next_txn = (port_en[p] && next_rcnt == '0) ? ~next_txp : 1'b0;
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        present <= 1'b0;
        link <= 1'b0;
        dead <= 1'b0;
        rcnt <= '0;
        txp <= 1'b0;
        port_tx_positive[p] <= 1'b0;
        port_tx_negative[p] <= 1'b0;
      end else begin
        present <= next_present;
        link <= next_link;
        dead <= next_dead;
        rcnt <= next_rcnt;
        txp <= next_txp;
        port_tx_positive[p] <= next_txp;
        port_tx_negative[p] <= next_txn;
      end
    end

    assign port_los[p] = los;
    assign port_present[p] = present;
    assign port_link[p] = link;
  end

endmodule // sata_legacy_taskfile_emulation

// ### verif/sata_tf_assertions.sv
`timescale 1ns/10ps
module sata_tf_checker
  import sata_tf_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic awready, // aw
  input wire logic wready, // w
  input wire logic bvalid, // b
  input wire logic bready, // b
  input wire logic [1:0] bresp, // b
  input wire logic rvalid, // r
  input wire logic rready, // r
  input wire logic [31:0] rdata, // r
  input wire logic activity_led_low_out, // led
  input wire logic activity_led_low_oe, // led
  input wire logic dma_setup_rx, // dma
  input wire logic dma_activate_rx, // dma
  input wire logic dma_go, // dma
  input wire logic fis_send, // fis
  input wire h2d_fis_t fis_out // fis
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin pulled low only, never driven high
  a_led_low_only: assert property (activity_led_low_oe |->
    !activity_led_low_out) else $error("led driven high");
  // dma start follows its causes only
  a_dma_activate: assert property (dma_activate_rx |=> dma_go)
    else $error("activate lost");
  a_dma_no_cause: assert property (!dma_activate_rx && !dma_setup_rx
    |=> !dma_go) else $error("dma start without cause");
  // fis strobe and header
  a_fis_one_cycle: assert property (fis_send |=> !fis_send)
    else $error("fis strobe too long");
  a_fis_header: assert property (fis_send |-> fis_out.fis_type ==
    FIS_H2D && fis_out.flags == FIS_CMD_FLAG) else $error("fis header");
  // bus answers stand until taken
  a_bresp_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read answer dropped");
  a_ready_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
endmodule // sata_tf_checker

bind sata_legacy_taskfile_emulation sata_tf_checker i_sata_tf_checker (.*);

// ### verif/sata_drive_model.sv
`timescale 1ns/10ps
module sata_drive_model (
  input wire logic aclk, // clock
  output logic master_done, // drive 0 done
  output logic slave_done, // drive 1 done
  output logic dma_setup_rx, // setup seen
  output logic dma_activate_rx, // activate seen
  output logic interlock_switch_input, // 0 closed
  output logic [3:0] port_rx_positive, // rx p
  output logic [3:0] port_rx_negative // rx n
);
  // drives present, switch open
  initial begin
    {dma_activate_rx, dma_setup_rx, slave_done, master_done} = 4'h0;
    interlock_switch_input = 1'h1;
    port_rx_positive = 4'hf;
    port_rx_negative = 4'h0;
  end
  // one-cycle pulse of {activate, setup, slave, master}
  task pulse(input logic [3:0] v);
    @(posedge aclk);
    {dma_activate_rx, dma_setup_rx, slave_done, master_done} <= v;
    @(posedge aclk);
    {dma_activate_rx, dma_setup_rx, slave_done, master_done} <= 4'h0;
  endtask
  // lane levels, equal levels mean no signal
  task rx(input logic [3:0] p, n);
    @(posedge aclk);
    port_rx_positive <= p;
    port_rx_negative <= n;
  endtask
  // switch level, low means closed
  task lock(input logic v);
    @(posedge aclk);
    interlock_switch_input <= v;
  endtask
endmodule // sata_drive_model

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sata_tf_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, dma_go, fis_send;
  logic activity_led_low_out, activity_led_low_oe, host_interrupt_line;
  logic master_done, slave_done, dma_setup_rx, dma_activate_rx;
  logic interlock_switch_input;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, port_tx_positive, port_tx_negative;
  logic [3:0] port_rx_positive, port_rx_negative;
  logic [1:0] bresp, rresp, resp;
  h2d_fis_t fis_out, fis_q;
  int err_total = 0, n_tests = 0, go_cnt = 0;

  sata_legacy_taskfile_emulation #(.RECOVER_CYCLES(4))
    i_sata_legacy_taskfile_emulation (.*);
  sata_drive_model i_sata_drive_model (.*);

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  // keep last fis, count dma starts
  always @(posedge aclk) begin
    if (fis_send) fis_q <= fis_out;
    if (dma_go) go_cnt <= go_cnt + 1;
  end

  task chk(input string name, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s exp %h got %h", name, exp, got);
    end
  endtask
  task wr(input logic [9:0] idx, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask
  task rdr(input logic [9:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    final_report;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    // capabilities with ahci off, then ahci and auto-activate on
    rdr(IDX_CAPS);
    chk("caps off", 32'h0000_0220, rd);
    wr(IDX_MODE, 32'h5);
    rdr(IDX_CAPS);
    chk("caps on", 32'h0000_027f, rd);
    i_sata_drive_model.pulse(4'h4);
    i_sata_drive_model.pulse(4'h8);
    wr(IDX_MODE, 32'h4);
    i_sata_drive_model.pulse(4'h4);
    repeat (2) @(posedge aclk);
    chk("dma go count", 32'h2, go_cnt);
    // switch closed then open
    for (int v = 0; v < 2; v++) begin
      i_sata_drive_model.lock(v[0]);
      repeat (3) @(posedge aclk);
      rdr(IDX_PORTS);
      chk("switch", 32'(!v[0]), 32'(rd[PR_SWITCH]));
    end
    // two writes, read latest then earlier
    wr(IDX_LBA_HIGH, 32'h11);
    wr(IDX_LBA_HIGH, 32'h22);
    for (int h = 0; h < 2; h++) begin
      wr(h ? IDX_DEVCTL_SEC : IDX_DEVCTL_PRI, 32'(h << DC_HOB));
      rdr(IDX_LBA_HIGH);
      chk("lba high", h ? 32'h11 : 32'h22, rd);
    end
    rdr(IDX_DEVCTL_PRI);
    chk("devctl read", {30'h0, RESP_OKAY}, {rd[29:0], resp});
    rdr(10'h3ff);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
    // diagnostic: master first, then slave first
    wr(IDX_DEVCTL_PRI, 32'h0);
    wr(IDX_INT_EN, 32'h1);
    // write with byte lane 0 off is ignored but answered
    wstrb <= 4'he;
    wr(IDX_LBA_HIGH, 32'h33);
    wstrb <= 4'hf;
    chk("lane off resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    rdr(IDX_LBA_HIGH);
    chk("lane off", 32'h22, rd);
    for (int s = 0; s < 2; s++) begin
      wr(IDX_CMD_STATUS, 32'(CMD_DIAG));
      rdr(IDX_CMD_STATUS);
      chk("busy", 32'h1, 32'(rd[ST_BSY]));
      chk("led", 32'h1, 32'(activity_led_low_oe));
      if (s) i_sata_drive_model.pulse(4'h2);
      i_sata_drive_model.pulse(4'h1);
      repeat (2) @(posedge aclk);
      chk("host_interrupt_line", 32'h1, 32'(host_interrupt_line));
      rdr(IDX_CMD_STATUS);
      chk("busy at master", 32'(!s), 32'(rd[ST_BSY]));
      if (!s) i_sata_drive_model.pulse(4'h2);
      rdr(IDX_CMD_STATUS);
      chk("busy end", 32'h0, 32'(rd[ST_BSY]));
    end
    chk("fis", 32'h0090_2211,
      {8'h0, fis_q.command, fis_q.lba2, fis_q.lba5});
    // mask, unmask, clear
    for (int e = 0; e < 3; e++) begin
      wr(e == 2 ? IDX_INT_CLR : IDX_INT_EN, 32'(e != 0));
      repeat (2) @(posedge aclk);
      chk("irq", 32'(e == 1), 32'(irq));
    end
    // link up, loss with recovery, then port off
    wr(IDX_MODE, 32'h1);
    wr(IDX_PORT_EN, 32'h1);
    repeat (3) @(posedge aclk);
    chk("tx lanes", 32'h1,
      32'({port_tx_positive[3:1], port_tx_negative[3:1],
      port_tx_positive[0] ^ port_tx_negative[0]}));
    rdr(IDX_PORTS);
    chk("link up", 32'h0000_01f1, rd);
    i_sata_drive_model.rx(4'hf, 4'h1);
    rdr(IDX_PORTS);
    chk("link lost", 32'h0000_00e1, rd);
    rdr(IDX_INT_STAT);
    chk("loss flag", 32'h1, 32'(rd[INT_LOS]));
    i_sata_drive_model.rx(4'hf, 4'h0);
    repeat (8) @(posedge aclk);
    rdr(IDX_PORTS);
    chk("relink", 32'h0000_01f1, rd);
    wr(IDX_PORT_EN, 32'h0);
    rdr(IDX_PORTS);
    chk("port off", 32'h0000_00f0, rd);
    chk("tx idle", 32'h0, 32'({port_tx_positive, port_tx_negative}));
    final_report;
  end
endmodule // tb_top
